// ===== pkg/ast_pkg.sv
// Constants, types and frame layout of the asynchronous serial transmitter
package ast_pkg;
   localparam int unsigned CLK_FREQ_HZ = 20000000;
   localparam int unsigned DATA_W = 8;
   localparam int unsigned BAUD_W = 16;
   localparam int unsigned FRAME_W = 11;
   localparam int unsigned CNT_W = 4;
   // Bits per frame: start, data word, stop
   localparam logic [CNT_W-1:0] FRAME_LEN_8 = 4'hA;
   localparam logic [CNT_W-1:0] FRAME_LEN_9 = 4'hB;
   localparam logic [CNT_W-1:0] MARK_LEN = 4'h1;
   // Field positions inside a frame image, bit 0 leaves first
   localparam int unsigned START_POS = 0;
   localparam int unsigned DATA_POS = 1;
   localparam int unsigned NINTH_POS = 9;
   localparam int unsigned STOP8_POS = 9;
   localparam int unsigned STOP9_POS = 10;
   localparam logic [FRAME_W-1:0] FRAME_ONES = 11'h7FF;
   localparam logic [FRAME_W-1:0] FRAME_ZEROS = 11'h000;
   // Reset values
   localparam logic TBE_RESET = 1'b1;
   localparam logic TC_RESET = 1'b1;
   localparam logic PIN_IDLE = 1'b1;
   localparam logic [BAUD_W-1:0] BAUD_CNT_RESET = 16'h0000;

   typedef enum logic [1:0] {
      AST_IDLE = 2'b00,
      AST_SEND = 2'b01,
      AST_MARK = 2'b10
   } ast_state_e;

   typedef enum logic [1:0] {
      AST_KIND_DATA = 2'b00,
      AST_KIND_IDLE = 2'b01,
      AST_KIND_BREAK = 2'b10,
      AST_KIND_MARK = 2'b11
   } ast_kind_e;

   // Control bits that software holds in the first control register
   typedef struct packed {
      logic tx_on;
      logic rx_on;
      logic word9;
      logic ninth_transmit_bit;
      logic send_break_ctl;
      logic tx_empty_irq_enable;
      logic frame_done_irq_enable;
      logic irq_mask;
   } ast_ctrl_s;
endpackage

// ===== hdl/ast_tx.sv
// Transmit side of the asynchronous serial interface
`timescale 1ns/1ps

module ast_tx
   import ast_pkg::*;
(
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire ast_ctrl_s ctrl_i,
   input wire logic [BAUD_W-1:0] tx_baud_div_i,
   input wire logic status_access_i,
   input wire logic data_write_i,
   input wire logic [DATA_W-1:0] data_i,
   output logic serial_out_o,
   output logic serial_oe_o,
   output logic tx_buffer_empty_flag_o,
   output logic frame_done_flag_o,
   output logic tx_empty_irq_o,
   output logic frame_done_irq_o,
   output logic busy_o
);

   ast_state_e state;
   ast_kind_e kind;
   logic [FRAME_W-1:0] shift;
   logic [CNT_W-1:0] bits_left;
   logic [BAUD_W-1:0] baud_cnt;
   logic [BAUD_W-1:0] baud_last;
   logic bit_tick;
   logic frame_end;
   logic can_start;
   logic [DATA_W-1:0] hold_data;
   logic hold_valid;
   logic hold_ninth;
   logic armed;
   logic tx_on_q;
   logic idle_pending;
   logic last_break;
   logic load_break;
   logic load_mark;
   logic load_idle;
   logic load_hold;
   logic load_direct;
   logic load_any;
   logic clear_seq;
   logic [FRAME_W-1:0] next_frame;
   logic [DATA_W-1:0] load_data;
   logic load_ninth;

   // A divider of zero is taken as one so the bit period is never empty
   assign baud_last = (tx_baud_div_i == BAUD_CNT_RESET) ?
      BAUD_CNT_RESET : tx_baud_div_i - 16'h0001;
   assign bit_tick = (state != AST_IDLE) && (baud_cnt == baud_last);
   assign frame_end = bit_tick && (bits_left == MARK_LEN);
   assign can_start = ((state == AST_IDLE) || frame_end) && ctrl_i.tx_on;
   assign clear_seq = data_write_i && armed;

   // Next frame choice, break first, then the closing one bit, then idle
   always_comb
   begin
      load_break = 1'b0;
      load_mark = 1'b0;
      load_idle = 1'b0;
      load_hold = 1'b0;
      load_direct = 1'b0;
      if (can_start)
      begin
         if (ctrl_i.send_break_ctl)
            load_break = 1'b1;
         else if (last_break)
            load_mark = 1'b1;
         else if (idle_pending || !tx_on_q)
            load_idle = 1'b1;
         else if (hold_valid)
            load_hold = 1'b1;
         else if (data_write_i && (state == AST_IDLE))
            load_direct = 1'b1;
      end
   end

   assign load_any = load_break | load_mark | load_idle | load_hold |
      load_direct;
   assign load_data = load_hold ? hold_data : data_i;
   assign load_ninth = load_hold ? hold_ninth : ctrl_i.ninth_transmit_bit;

   // Frame image, start bit at bit 0; the all-ones fill gives the stop bit
   always_comb
   begin
      next_frame = FRAME_ONES;
      if (load_break)
         next_frame = FRAME_ZEROS;
      else if (load_hold || load_direct)
      begin
         next_frame[START_POS] = 1'b0;
         next_frame[DATA_POS +: DATA_W] = load_data;
         if (ctrl_i.word9)
            next_frame[NINTH_POS] = load_ninth;
      end
   end

   // Bit timing restarts with each frame so every bit is one full period
   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         baud_cnt <= BAUD_CNT_RESET;
      else if (load_any || bit_tick || (state == AST_IDLE))
         baud_cnt <= BAUD_CNT_RESET;
      else
         baud_cnt <= baud_cnt + 16'h0001;
   end

   // Frame sequencer
   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         state <= AST_IDLE;
         kind <= AST_KIND_IDLE;
         shift <= FRAME_ONES;
         bits_left <= MARK_LEN;
      end
      else if (load_any)
      begin
         state <= load_mark ? AST_MARK : AST_SEND;
         shift <= next_frame;
         kind <= load_mark ? AST_KIND_MARK : load_break ? AST_KIND_BREAK :
            load_idle ? AST_KIND_IDLE : AST_KIND_DATA;
         bits_left <= load_mark ? MARK_LEN :
            (ctrl_i.word9 ? FRAME_LEN_9 : FRAME_LEN_8);
      end
      else if (frame_end)
      begin
         state <= AST_IDLE;
         shift <= FRAME_ONES;
      end
      else if (bit_tick)
      begin
         shift <= {1'b1, shift[FRAME_W-1:1]};
         bits_left <= bits_left - 4'h1;
      end
   end

   // Break history, so one mark bit closes the last break frame
   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         last_break <= 1'b0;
      else if (load_any)
         last_break <= load_break;
      else if (!ctrl_i.tx_on)
         last_break <= 1'b0;
   end

   // Transmitter-on edge requests one idle frame before the next data
   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         tx_on_q <= 1'b0;
         idle_pending <= 1'b0;
      end
      else
      begin
         tx_on_q <= ctrl_i.tx_on;
         if (load_idle)
            idle_pending <= 1'b0;
         else if (ctrl_i.tx_on && !tx_on_q)
            idle_pending <= 1'b1;
      end
   end

   // Holding buffer; a transmitter-off drops what it holds
   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         hold_valid <= 1'b0;
         hold_data <= '0;
         hold_ninth <= 1'b0;
      end
      else if (data_write_i && !load_direct)
      begin
         hold_valid <= 1'b1;
         hold_data <= data_i;
         hold_ninth <= ctrl_i.ninth_transmit_bit;
      end
      else if (load_hold || !ctrl_i.tx_on)
         hold_valid <= 1'b0;
   end

   // Status access arms the clear; the following data write consumes it
   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         armed <= 1'b0;
      else if (status_access_i)
         armed <= 1'b1;
      else if (data_write_i)
         armed <= 1'b0;
   end

   // Flags: a set in the clearing cycle wins
   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         tx_buffer_empty_flag_o <= TBE_RESET;
         frame_done_flag_o <= TC_RESET;
      end
      else
      begin
         if (load_hold || load_direct)
            tx_buffer_empty_flag_o <= 1'b1;
         else if (clear_seq)
            tx_buffer_empty_flag_o <= 1'b0;
         if (frame_end)
            frame_done_flag_o <= 1'b1;
         else if (clear_seq)
            frame_done_flag_o <= 1'b0;
      end
   end

   // Interrupt requests follow the flags by one cycle
   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         tx_empty_irq_o <= 1'b0;
         frame_done_irq_o <= 1'b0;
      end
      else
      begin
         tx_empty_irq_o <= tx_buffer_empty_flag_o &&
            ctrl_i.tx_empty_irq_enable && !ctrl_i.irq_mask;
         frame_done_irq_o <= frame_done_flag_o &&
            ctrl_i.frame_done_irq_enable && !ctrl_i.irq_mask;
      end
   end

   // Pin drive; the output lags the shifter by one cycle
   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         serial_out_o <= PIN_IDLE;
         serial_oe_o <= 1'b0;
         busy_o <= 1'b0;
      end
      else
      begin
         serial_oe_o <= ctrl_i.tx_on || ctrl_i.rx_on;
         serial_out_o <= (state == AST_IDLE) ? PIN_IDLE : shift[0];
         busy_o <= (state != AST_IDLE);
      end
   end

   frame_len_a: assert property (
      @(posedge clk_i) disable iff (!nrst_i)
      (load_hold || load_direct) |=>
         bits_left == ($past(ctrl_i.word9) ? FRAME_LEN_9 : FRAME_LEN_8))
      else $error("data frame length does not match word length");

   start_low_a: assert property (
      @(posedge clk_i) disable iff (!nrst_i)
      (load_hold || load_direct) |-> ##2 !serial_out_o)
      else $error("start bit not low on pin");

   stop_high_a: assert property (
      @(posedge clk_i) disable iff (!nrst_i)
      (state == AST_SEND && kind == AST_KIND_DATA && bits_left == MARK_LEN)
         |=> serial_out_o)
      else $error("stop bit not high on pin");

   lsb_first_a: assert property (
      @(posedge clk_i) disable iff (!nrst_i)
      load_direct |=> shift[DATA_POS] == $past(data_i[0]))
      else $error("first data bit is not the lsb");

   ninth_bit_a: assert property (
      @(posedge clk_i) disable iff (!nrst_i)
      (load_direct && ctrl_i.word9) |=>
         shift[NINTH_POS] == $past(ctrl_i.ninth_transmit_bit))
      else $error("ninth bit not taken from control");

   idle_ones_a: assert property (
      @(posedge clk_i) disable iff (!nrst_i)
      (state == AST_SEND && kind == AST_KIND_IDLE) |-> (&shift))
      else $error("idle frame holds a zero");

   break_mark_a: assert property (
      @(posedge clk_i) disable iff (!nrst_i)
      (frame_end && kind == AST_KIND_BREAK && ctrl_i.tx_on &&
         !ctrl_i.send_break_ctl) |=> state == AST_MARK ##2 serial_out_o)
      else $error("no one bit after last break frame");

   pin_release_a: assert property (
      @(posedge clk_i) disable iff (!nrst_i)
      (!ctrl_i.tx_on && !ctrl_i.rx_on) |=> !serial_oe_o)
      else $error("pin still claimed while both sides off");

   idle_high_a: assert property (
      @(posedge clk_i) disable iff (!nrst_i)
      (state == AST_IDLE && (ctrl_i.tx_on || ctrl_i.rx_on))
         |=> serial_out_o && serial_oe_o)
      else $error("idle pin not driven high");

   on_idle_a: assert property (
      @(posedge clk_i) disable iff (!nrst_i)
      (ctrl_i.tx_on && !tx_on_q && state == AST_IDLE &&
         !ctrl_i.send_break_ctl && !last_break) |=> kind == AST_KIND_IDLE)
      else $error("no idle frame after transmitter on");

   tbe_hold_a: assert property (
      @(posedge clk_i) disable iff (!nrst_i)
      (tx_buffer_empty_flag_o && !clear_seq) |=> tx_buffer_empty_flag_o)
      else $error("buffer empty cleared without access pair");

   tbe_set_a: assert property (
      @(posedge clk_i) disable iff (!nrst_i)
      load_hold |=> tx_buffer_empty_flag_o && !hold_valid || $past(data_write_i))
      else $error("buffer empty not set on transfer");

   tc_set_a: assert property (
      @(posedge clk_i) disable iff (!nrst_i)
      frame_end |=> frame_done_flag_o ##1
         (frame_done_irq_o == (ctrl_i.frame_done_irq_enable &&
            !ctrl_i.irq_mask) || $changed(ctrl_i)))
      else $error("frame done not set after stop bit");

   bit_steady_a: assert property (
      @(posedge clk_i) disable iff (!nrst_i)
      (state != AST_IDLE && !bit_tick && !load_any) |=>
         bits_left == $past(bits_left) && $stable(shift))
      else $error("shifter moved between bit ticks");

endmodule

// ===== testbench/ast_rx_model.sv
// Receiving equipment model: decodes frames seen on the serial pin
`timescale 1ns/1ps

module ast_rx_model
   import ast_pkg::*;
(
   input wire logic clk_i,
   input wire logic line_i,
   input wire logic oe_i,
   input wire logic word9_i,
   input wire logic [BAUD_W-1:0] div_i,
   output logic [8:0] word_o,
   output logic stop_o,
   output int count_o
);
   logic [8:0] w;

   // Samples each bit near its middle, counted from the start edge
   initial
   begin
      count_o = 0;
      word_o = '0;
      stop_o = 1'b0;
      forever
      begin
         @(negedge line_i);
         if (oe_i === 1'b1)
         begin
            repeat (div_i / 2) @(posedge clk_i);
            w = '0;
            for (int i = 0; i < (word9_i ? 9 : 8); i++)
            begin
               repeat (div_i) @(posedge clk_i);
               w[i] = line_i;
            end
            repeat (div_i) @(posedge clk_i);
            stop_o = line_i;
            word_o = w;
            count_o++;
         end
      end
   end
endmodule

// ===== testbench/tb_async_serial_transmitter.sv
// Self-checking bench of the serial transmitter
`timescale 1ns/1ps

module tb_async_serial_transmitter;
   import ast_pkg::*;
   localparam int DIV = 4;
   logic clk_i;
   logic nrst_i;
   ast_ctrl_s ctrl;
   ast_ctrl_s dut_ctrl;
   logic [BAUD_W-1:0] div;
   logic sa;
   logic dw;
   logic [DATA_W-1:0] dat;
   logic sout;
   logic soe;
   logic tbe;
   logic fd;
   logic tirq;
   logic firq;
   logic busy;
   logic [8:0] rword;
   logic rstop;
   int rcnt;
   int err_count;
   int num_checks;
   int l;
   int b;

   ast_tx dut (.clk_i(clk_i), .nrst_i(nrst_i), .ctrl_i(dut_ctrl),
      .tx_baud_div_i(div), .status_access_i(sa), .data_write_i(dw),
      .data_i(dat), .serial_out_o(sout), .serial_oe_o(soe),
      .tx_buffer_empty_flag_o(tbe), .frame_done_flag_o(fd),
      .tx_empty_irq_o(tirq), .frame_done_irq_o(firq), .busy_o(busy));

   ast_rx_model rx (.clk_i(clk_i), .line_i(sout), .oe_i(soe),
      .word9_i(dut_ctrl.word9), .div_i(div), .word_o(rword),
      .stop_o(rstop), .count_o(rcnt));

   initial
   begin
      clk_i = 1'b0;
      forever #25 clk_i = ~clk_i;
   end

   task wrap_up;
      $display("checks %0d errors %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task chk(input string n, input logic [15:0] e, input logic [15:0] g);
      num_checks++;
      if (g !== e)
      begin
         err_count++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask

   task cyc(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask

   task setc(input ast_ctrl_s c);
      @(posedge clk_i);
      dut_ctrl <= c;
      #1;
   endtask

   // One-cycle pulses, as the CPU side produces them
   task acc;
      @(posedge clk_i);
      sa <= 1'b1;
      @(posedge clk_i);
      sa <= 1'b0;
      #1;
   endtask

   task wr(input logic [DATA_W-1:0] d);
      @(posedge clk_i);
      dw <= 1'b1;
      dat <= d;
      @(posedge clk_i);
      dw <= 1'b0;
      #1;
   endtask

   task give_up;
      err_count++;
      $display("mismatch wait expired");
      wrap_up;
   endtask

   task waitlow(output int w);
      w = 0;
      while (sout !== 1'b0)
      begin
         cyc(1);
         w++;
         if (w > 3000)
            give_up;
      end
   endtask

   task lowrun(output int n);
      int w;
      waitlow(w);
      n = 0;
      while (sout === 1'b0 && n < 3000)
      begin
         cyc(1);
         n++;
      end
      if (n >= 3000)
         give_up;
   endtask

   task frames(input int n);
      int w;
      w = 0;
      while (rcnt < n)
      begin
         cyc(1);
         w++;
         if (w > 3000)
            give_up;
      end
   endtask

   task wait_idle;
      cyc(2);
      for (int w = 0; busy !== 1'b0; w++)
      begin
         cyc(1);
         if (w > 3000)
            give_up;
      end
   endtask

   task count_pin(input int n, output int lo, output int bz);
      lo = 0;
      bz = 0;
      repeat (n)
      begin
         cyc(1);
         lo += (sout === 1'b0);
         bz += (busy === 1'b1);
      end
   endtask

   initial
   begin
      err_count = 0;
      num_checks = 0;
      nrst_i = 1'b0;
      ctrl = '0;
      dut_ctrl = '0;
      div = DIV;
      sa = 1'b0;
      dw = 1'b0;
      dat = '0;
      repeat (2) @(posedge clk_i);
      nrst_i <= 1'b1;
      cyc(2);
      chk("tbe", 1, tbe);
      chk("pin", 1, sout);
      chk("oe", 0, soe);
      ctrl.rx_on = 1'b1;
      setc(ctrl);
      cyc(3);
      chk("oe_rx", 1, soe);
      ctrl.tx_on = 1'b1;
      setc(ctrl);
      count_pin(10 * DIV, l, b);
      chk("idle_low", 0, l);
      chk("idle_busy", 1, b > 0);
      wait_idle;
      // Direct start while idle
      acc;
      wr(8'hA5);
      cyc(1);
      chk("tbe_direct", 1, tbe);
      chk("fd_clear", 0, fd);
      lowrun(l);
      chk("start_len", DIV, l);
      frames(1);
      chk("word", 16'h0A5, rword);
      chk("stop", 1, rstop);
      cyc(2 * DIV);
      chk("fd_set", 1, fd);
      // Interrupt gating and buffered writes
      ctrl.tx_empty_irq_enable = 1'b1;
      ctrl.frame_done_irq_enable = 1'b1;
      ctrl.irq_mask = 1'b1;
      setc(ctrl);
      cyc(3);
      chk("tirq_mask", 0, tirq);
      chk("firq_mask", 0, firq);
      ctrl.irq_mask = 1'b0;
      setc(ctrl);
      cyc(3);
      chk("tirq", 1, tirq);
      chk("firq", 1, firq);
      acc;
      wr(8'h5A);
      wr(8'h11);
      cyc(1);
      chk("tbe_noacc", 1, tbe);
      acc;
      wr(8'hC3);
      cyc(2);
      chk("tbe_clr", 0, tbe);
      chk("tirq_off", 0, tirq);
      chk("firq_off", 0, firq);
      frames(2);
      chk("word_first", 16'h05A, rword);
      cyc(2 * DIV);
      chk("tbe_move", 1, tbe);
      chk("tirq_on", 1, tirq);
      frames(3);
      chk("word_held", 16'h0C3, rword);
      wait_idle;
      // Nine-bit words, ninth bit from the control field
      ctrl.word9 = 1'b1;
      for (int i = 0; i < 2; i++)
      begin
         ctrl.ninth_transmit_bit = (i == 0);
         setc(ctrl);
         wr(i == 0 ? 8'h3C : 8'hFF);
         frames(4 + i);
         chk("word9", i == 0 ? 16'h13C : 16'h0FF, rword);
         chk("stop9", 1, rstop);
         wait_idle;
      end
      // Break: the low run ends on a frame boundary, then a mark bit
      ctrl.word9 = 1'b0;
      ctrl.send_break_ctl = 1'b1;
      setc(ctrl);
      waitlow(l);
      cyc(25 * DIV);
      ctrl.send_break_ctl = 1'b0;
      setc(ctrl);
      lowrun(l);
      chk("break_len", 30 * DIV, 25 * DIV + 1 + l);
      count_pin(DIV - 1, l, b);
      chk("break_mark", 0, l);
      wait_idle;
      // Toggling the transmitter mid-frame queues an idle frame
      b = rcnt;
      wr(8'h81);
      cyc(3 * DIV);
      ctrl.tx_on = 1'b0;
      setc(ctrl);
      ctrl.tx_on = 1'b1;
      setc(ctrl);
      frames(b + 1);
      chk("word_tog", 16'h081, rword);
      acc;
      wr(8'h42);
      waitlow(l);
      chk("idle_gap", 1, l >= 9 * DIV);
      frames(b + 2);
      chk("word_after", 16'h042, rword);
      wait_idle;
      ctrl = '0;
      setc(ctrl);
      cyc(3);
      chk("oe_off", 0, soe);
      wrap_up;
   end
endmodule
